// *** dv/epcp_eeprom_model.sv ***
`timescale 1ns/1ps
module epcp_eeprom_model (
  input wire logic clk_sys,
  input wire logic eep_req,
  input wire logic [7:0] eep_addr,
  input wire logic slow,
  input wire logic inv,
  output logic eep_ack,
  output logic [15:0] eep_rdata
);
  logic [1:0] wait_q = 2'h0;
  logic [15:0] word;
  initial eep_ack = 1'b0;
  assign word = {~eep_addr, eep_addr} ^ {16{inv}};
  // data only valid with the answer
  assign eep_rdata = eep_ack ? word : ~word;
  always @(posedge clk_sys) begin
    if (eep_req && !eep_ack && wait_q >= (slow ? 2'h3 : 2'h0)) begin
      eep_ack <= 1'b1;
      wait_q <= 2'h0;
    end else begin
      eep_ack <= 1'b0;
      wait_q <= (eep_req && !eep_ack) ? wait_q + 2'h1 : 2'h0;
    end
  end
endmodule

// *** dv/epcp_preload_assertions.sv ***
`timescale 1ns/1ps
module epcp_preload_checker #(
  parameter int NPORT = 6
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic reload,
  input wire logic eep_req,
  input wire logic [7:0] eep_addr,
  input wire logic eep_ack,
  input wire logic [15:0] eep_rdata,
  input wire logic cfg_rd,
  input wire logic cfg_rvalid,
  input wire logic preload_busy,
  input wire logic preload_done,
  input wire logic [NPORT-1:0][31:0] link_layer_timer_control,
  input wire logic [NPORT-1:0][31:0] port_phy_control,
  input wire logic [NPORT-1:0][31:0] power_mgmt_capability_control
);
  logic [15:0] cap_q;
  wire logic tk = eep_req && eep_ack;
  always_ff @(posedge clk_sys) begin
    if (tk) begin
      cap_q <= eep_rdata;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_req_hold: assert property (eep_req && !eep_ack |=> eep_req && $stable(eep_addr))
    else $error("request moved");
  a_addr_step: assert property (tk && eep_addr != 8'hDA && eep_addr != 8'hEA
    && eep_addr != 8'hF4 |=> ##1 eep_req && eep_addr == $past(eep_addr, 2) + 8'h02)
    else $error("bad address step");
  a_addr_jump: assert property (tk && eep_addr == 8'hDA |=> ##1 eep_addr == 8'hE0)
    else $error("bad jump");
  a_ctrl_jump: assert property (tk && eep_addr == 8'hEA |=> ##1 eep_addr == 8'hF0)
    else $error("bad jump to control words");
  a_last_word: assert property (tk && eep_addr == 8'hF4 |=> ##1 preload_done && !eep_req)
    else $error("bad end");
  a_replay_fld: assert property (tk && eep_addr == 8'hD6 |=> ##1
    link_layer_timer_control[3][12:0] == cap_q[12:0] && port_phy_control[3][25:24] == cap_q[14:13])
    else $error("replay field");
  a_ack_fld: assert property (tk && eep_addr == 8'hEA |=> ##1
    link_layer_timer_control[5][30:16] == cap_q[14:0]) else $error("ack field");
  a_ctrl_fld: assert property (tk && eep_addr == 8'hF0 |=> ##1
    port_phy_control[0][23:10] == {cap_q[7:0], 4'h0, cap_q[14], cap_q[12]})
    else $error("control field");
  a_pm_fld: assert property (tk && eep_addr == 8'hF4 |=> ##1
    power_mgmt_capability_control[2][0] == cap_q[13]) else $error("pm field");
  a_keep_bits: assert property (preload_busy |=>
    $stable({link_layer_timer_control[0][15:13], power_mgmt_capability_control[0]}))
    else $error("other bits moved");
  c_slow: cover property (eep_req [*3] ##1 tk);
  c_reload: cover property (reload && !preload_busy);
  c_read: cover property (cfg_rd ##1 cfg_rvalid);
endmodule
bind epcp_preload epcp_preload_checker #(.NPORT(NPORT)) i_chk (.clk_sys, .rst_n, .reload,
  .eep_req, .eep_addr, .eep_ack, .eep_rdata, .cfg_rd, .cfg_rvalid, .preload_busy, .preload_done,
  .link_layer_timer_control, .port_phy_control, .power_mgmt_capability_control);

// *** dv/test_eeprom_port_config_preload.sv ***
`timescale 1ns/1ps
module test_eeprom_port_config_preload;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic reload = 1'b0;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic slow = 1'b0;
  logic inv = 1'b0;
  logic eep_req, eep_ack, cfg_rvalid, preload_busy, preload_done;
  logic [2:0] cfg_port = 3'h0;
  logic [7:0] cfg_offset = 8'h00;
  logic [7:0] eep_addr;
  logic [15:0] eep_rdata;
  logic [31:0] cfg_wdata = 32'h00000000;
  logic [31:0] cfg_rdata;
  logic [5:0][31:0] lltc, phy, pmc;
  logic [5:0][31:0] e_l = '0, e_p = '0, e_m = '0;
  int error_cnt = 0;
  int checks_done = 0;
  epcp_preload #(.NPORT(6)) i_dut (.clk_sys, .rst_n, .reload, .eep_req, .eep_addr, .eep_ack,
    .eep_rdata, .cfg_wr, .cfg_rd, .cfg_port, .cfg_offset, .cfg_wdata, .cfg_rdata, .cfg_rvalid,
    .preload_busy, .preload_done, .link_layer_timer_control(lltc), .port_phy_control(phy),
    .power_mgmt_capability_control(pmc));
  epcp_eeprom_model i_eeprom (.clk_sys, .eep_req, .eep_addr, .slow, .inv, .eep_ack, .eep_rdata);
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // expected images after a preload with memory words {~a, a} ^ v
  task automatic apply(input logic v);
    logic [15:0] w;
    for (int p = 0; p < 6; p++) begin
      if (p > 2) begin
        w = {~(8'hD6 + 8'(2 * p - 6)), 8'hD6 + 8'(2 * p - 6)} ^ {16{v}};
        e_l[p][12:0] = w[12:0];
        e_p[p][25:24] = w[14:13];
      end
      w = {~(8'hE0 + 8'(2 * p)), 8'hE0 + 8'(2 * p)} ^ {16{v}};
      e_l[p][30:16] = w[14:0];
      if (p < 3) begin
        w = {~(8'hF0 + 8'(2 * p)), 8'hF0 + 8'(2 * p)} ^ {16{v}};
        e_p[p][23:16] = w[7:0];
        e_p[p][11:10] = {w[14], w[12]};
        e_m[p][0] = (p > 0) ? w[13] : e_m[p][0];
      end
    end
  endtask
  task automatic check_all;
    for (int p = 0; p < 6; p++) begin
      chk("timer control", e_l[p], lltc[p]);
      chk("phy control", e_p[p], phy[p]);
      chk("pm control", e_m[p], pmc[p]);
    end
  endtask
  task automatic acc(input logic w, input logic [2:0] p, input logic [7:0] o,
    input logic [31:0] d);
    @(negedge clk_sys);
    cfg_wr = w;
    cfg_rd = !w;
    cfg_port = p;
    cfg_offset = o;
    cfg_wdata = d;
    @(negedge clk_sys);
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    if (!w) begin
      chk("read valid", 32'h00000001, 32'(cfg_rvalid));
      chk("read data", d, cfg_rdata);
    end
  endtask
  task automatic wait_done;
    int n;
    n = 0;
    while (!(preload_done === 1'b1 && preload_busy === 1'b0) && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
    chk("preload done", 32'h00000001, 32'(preload_done));
  endtask
  task automatic t_boot;
    wait_done();
    apply(1'b0);
    check_all();
    acc(1'b0, 3'h3, 8'h70, e_l[3]);
    acc(1'b0, 3'h1, 8'h9C, e_m[1]);
    acc(1'b0, 3'h0, 8'h74, 32'h00000000);
    $display("boot preload done");
  endtask
  task automatic t_soft;
    acc(1'b1, 3'h0, 8'h70, 32'hFFFFFFFF);
    acc(1'b1, 3'h4, 8'h8C, 32'hFFFFFFFF);
    acc(1'b1, 3'h0, 8'h9C, 32'hFFFFFFFF);
    acc(1'b1, 3'h1, 8'h74, 32'hFFFFFFFF);
    e_l[0] = '1;
    e_p[4] = '1;
    e_m[0] = '1;
    check_all();
    $display("software writes done");
  endtask
  task automatic t_reload;
    slow = 1'b1;
    inv = 1'b1;
    @(negedge clk_sys);
    reload = 1'b1;
    @(negedge clk_sys);
    reload = 1'b0;
    acc(1'b1, 3'h2, 8'h70, 32'h00000000);
    // a second reload while busy must not restart the sequence
    @(negedge clk_sys);
    reload = 1'b1;
    @(negedge clk_sys);
    reload = 1'b0;
    wait_done();
    apply(1'b1);
    check_all();
    acc(1'b0, 3'h5, 8'h8C, e_p[5]);
    $display("slow reload done");
  endtask
  initial begin
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    t_boot();
    t_soft();
    t_reload();
    tally_and_finish();
  end
  initial begin
    repeat (3000) @(posedge clk_sys);
    error_cnt++;
    tally_and_finish();
  end
endmodule

// *** hw/epcp_params.svh ***
`ifndef EPCP_PARAMS_SVH
`define EPCP_PARAMS_SVH
// What this block does
// - replay word bits 11:0 to 70h timeout, ports 3-5
// - replay word bit 12 to 70h enable bit 12
// - replay word bits 14:13 to 8Ch 25:24
// - ack word bits 13:0 to 70h 29:16
// - ack word bit 14 to 70h bit 30
// - control word bits 7:0 to 8Ch 23:16
// - control word bit 12 to 8Ch bit 10
// - control word bit 14 to 8Ch bit 11
// - ports 1-2 control bit 13 to 9Ch bit 0

// ----------------------------------------
// sequence and memory layout
// ----------------------------------------
`define EPCP_NUM_PORTS 6
`define EPCP_NUM_STEPS 4'hC
`define EPCP_LAST_STEP 4'hB
`define EPCP_WORD_STRIDE 8'h02
`define EPCP_EE_REPLAY_BASE 8'hD6
`define EPCP_REPLAY_FIRST_PORT 3'h3
`define EPCP_REPLAY_STEPS 4'h3
`define EPCP_EE_ACK_BASE 8'hE0
`define EPCP_ACK_STEPS 4'h6
`define EPCP_EE_CTRL_BASE 8'hF0
`define EPCP_PM_FIRST_PORT 3'h1

// ----------------------------------------
// configuration offsets and reset values
// ----------------------------------------
`define EPCP_OFS_LLTC 8'h70
`define EPCP_OFS_PHY 8'h8C
`define EPCP_OFS_PM 8'h9C
`define EPCP_RST_LLTC 32'h00000000
`define EPCP_RST_PHY 32'h00000000
`define EPCP_RST_PM 32'h00000000

// ----------------------------------------
// field positions
// ----------------------------------------
`define EPCP_RPL_HI 11
`define EPCP_RPL_LO 0
`define EPCP_RPL_EN 12
`define EPCP_TS_SRC_HI 14
`define EPCP_TS_SRC_LO 13
`define EPCP_TS_DST_HI 25
`define EPCP_TS_DST_LO 24
`define EPCP_ACK_SRC_HI 13
`define EPCP_ACK_SRC_LO 0
`define EPCP_ACK_DST_HI 29
`define EPCP_ACK_DST_LO 16
`define EPCP_ACK_EN_SRC 14
`define EPCP_ACK_EN_DST 30
`define EPCP_PHY6_SRC_HI 7
`define EPCP_PHY6_SRC_LO 0
`define EPCP_PHY6_DST_HI 23
`define EPCP_PHY6_DST_LO 16
`define EPCP_DIS_SRC 12
`define EPCP_DIS_DST 10
`define EPCP_RSEL_SRC 14
`define EPCP_RSEL_DST 11
`define EPCP_PMC_SRC 13
`define EPCP_PMC_DST 0
`endif

// *** hw/epcp_pkg.sv ***
package epcp_pkg;
  `include "epcp_params.svh"

  typedef enum logic [1:0] {
    EPCP_KIND_REPLAY = 2'h0,
    EPCP_KIND_ACK = 2'h1,
    EPCP_KIND_CTRL = 2'h2
  } epcp_kind_t;

  typedef struct packed {
    epcp_kind_t kind;
    logic [2:0] port;
    logic [7:0] addr;
  } epcp_step_t;

  // step index to memory word address, kind and target port
  function automatic epcp_step_t epcp_step_decode(input logic [3:0] step);
    epcp_step_t s;
    logic [3:0] idx;
    s = '{kind: EPCP_KIND_REPLAY, port: 3'h0, addr: 8'h00};
    idx = 4'h0;
    if (step < `EPCP_REPLAY_STEPS) begin
      idx = step;
      s.kind = EPCP_KIND_REPLAY;
      s.port = 3'(idx) + `EPCP_REPLAY_FIRST_PORT;
      s.addr = `EPCP_EE_REPLAY_BASE + 8'(idx) * `EPCP_WORD_STRIDE;
    end else if (step < `EPCP_REPLAY_STEPS + `EPCP_ACK_STEPS) begin
      idx = step - `EPCP_REPLAY_STEPS;
      s.kind = EPCP_KIND_ACK;
      s.port = 3'(idx);
      s.addr = `EPCP_EE_ACK_BASE + 8'(idx) * `EPCP_WORD_STRIDE;
    end else begin
      idx = step - `EPCP_REPLAY_STEPS - `EPCP_ACK_STEPS;
      s.kind = EPCP_KIND_CTRL;
      s.port = 3'(idx);
      s.addr = `EPCP_EE_CTRL_BASE + 8'(idx) * `EPCP_WORD_STRIDE;
    end
    return s;
  endfunction
endpackage

// *** hw/epcp_preload.sv ***
`timescale 1ns/1ps
`include "epcp_params.svh"
module epcp_preload #(
  parameter int NPORT = `EPCP_NUM_PORTS
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic reload,
  output logic eep_req,
  output logic [7:0] eep_addr,
  input wire logic eep_ack,
  input wire logic [15:0] eep_rdata,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [2:0] cfg_port,
  input wire logic [7:0] cfg_offset,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  output logic preload_busy,
  output logic preload_done,
  output logic [NPORT-1:0][31:0] link_layer_timer_control,
  output logic [NPORT-1:0][31:0] port_phy_control,
  output logic [NPORT-1:0][31:0] power_mgmt_capability_control
);
  import epcp_pkg::*;

  // ----------------------------------------
  // configuration decode helpers
  // ----------------------------------------
  localparam logic [1:0] SEL_LLTC = 2'h0;
  localparam logic [1:0] SEL_PHY = 2'h1;
  localparam logic [1:0] SEL_PM = 2'h2;
  localparam logic [1:0] SEL_NONE = 2'h3;

  // register select of an offset, none when unmapped
  function automatic logic [1:0] epcp_ofs_sel(input logic [7:0] ofs);
    logic [1:0] sel;
    sel = SEL_NONE;
    if (ofs == `EPCP_OFS_LLTC) begin
      sel = SEL_LLTC;
    end else if (ofs == `EPCP_OFS_PHY) begin
      sel = SEL_PHY;
    end else if (ofs == `EPCP_OFS_PM) begin
      sel = SEL_PM;
    end
    return sel;
  endfunction

  // port index within the built ports
  function automatic logic epcp_port_ok(input logic [2:0] port);
    return 32'(port) < NPORT;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [NPORT-1:0][31:0] lltc;
    logic [NPORT-1:0][31:0] phy;
    logic [NPORT-1:0][31:0] pm;
    logic kick;
    logic done;
    logic [31:0] rdata;
    logic rvalid;
  } epcp_main_t;

  epcp_main_t s_q;
  epcp_main_t s_d;

  logic fetch_start;
  logic word_valid;
  logic [3:0] word_step;
  logic [15:0] word_data;
  logic busy;
  epcp_step_t info;
  logic [1:0] ofs_sel;
  logic port_ok;

  assign ofs_sel = epcp_ofs_sel(cfg_offset);
  assign port_ok = epcp_port_ok(cfg_port);

  // reload is ignored until the last merge has landed
  assign fetch_start = s_q.kick || (reload && !preload_busy);

  epcp_word_fetch u_fetch (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(fetch_start),
    .eep_req(eep_req),
    .eep_addr(eep_addr),
    .eep_ack(eep_ack),
    .eep_rdata(eep_rdata),
    .word_valid(word_valid),
    .word_step(word_step),
    .word_data(word_data),
    .busy(busy)
  );

  assign info = epcp_step_decode(word_step);

  // ----------------------------------------
  // field merge and configuration access
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.kick = 1'b0;
    s_d.rvalid = cfg_rd;
    if (fetch_start) begin
      s_d.done = 1'b0;
    end
    if (word_valid) begin
      unique case (info.kind)
        EPCP_KIND_REPLAY: begin
          s_d.lltc[info.port][`EPCP_RPL_HI:`EPCP_RPL_LO] =
            word_data[`EPCP_RPL_HI:`EPCP_RPL_LO];
          s_d.lltc[info.port][`EPCP_RPL_EN] = word_data[`EPCP_RPL_EN];
          s_d.phy[info.port][`EPCP_TS_DST_HI:`EPCP_TS_DST_LO] =
            word_data[`EPCP_TS_SRC_HI:`EPCP_TS_SRC_LO];
        end
        EPCP_KIND_ACK: begin
          s_d.lltc[info.port][`EPCP_ACK_DST_HI:`EPCP_ACK_DST_LO] =
            word_data[`EPCP_ACK_SRC_HI:`EPCP_ACK_SRC_LO];
          s_d.lltc[info.port][`EPCP_ACK_EN_DST] = word_data[`EPCP_ACK_EN_SRC];
        end
        default: begin
          s_d.phy[info.port][`EPCP_PHY6_DST_HI:`EPCP_PHY6_DST_LO] =
            word_data[`EPCP_PHY6_SRC_HI:`EPCP_PHY6_SRC_LO];
          s_d.phy[info.port][`EPCP_DIS_DST] = word_data[`EPCP_DIS_SRC];
          s_d.phy[info.port][`EPCP_RSEL_DST] = word_data[`EPCP_RSEL_SRC];
          if (info.port >= `EPCP_PM_FIRST_PORT) begin
            s_d.pm[info.port][`EPCP_PMC_DST] = word_data[`EPCP_PMC_SRC];
          end
          if (word_step == `EPCP_LAST_STEP) begin
            s_d.done = 1'b1;
          end
        end
      endcase
    end
    // software writes are dropped until the last merge has landed
    if (cfg_wr && !preload_busy && port_ok) begin
      unique case (ofs_sel)
        SEL_LLTC: begin
          s_d.lltc[cfg_port] = cfg_wdata;
        end
        SEL_PHY: begin
          s_d.phy[cfg_port] = cfg_wdata;
        end
        SEL_PM: begin
          s_d.pm[cfg_port] = cfg_wdata;
        end
        default: begin
        end
      endcase
    end
    // read path, zero for unmapped offsets and ports
    s_d.rdata = 32'h00000000;
    if (cfg_rd && port_ok) begin
      unique case (ofs_sel)
        SEL_LLTC: begin
          s_d.rdata = s_q.lltc[cfg_port];
        end
        SEL_PHY: begin
          s_d.rdata = s_q.phy[cfg_port];
        end
        SEL_PM: begin
          s_d.rdata = s_q.pm[cfg_port];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_q.lltc <= {NPORT{`EPCP_RST_LLTC}};
      s_q.phy <= {NPORT{`EPCP_RST_PHY}};
      s_q.pm <= {NPORT{`EPCP_RST_PM}};
      s_q.kick <= 1'b1;
      s_q.done <= 1'b0;
      s_q.rdata <= 32'h00000000;
      s_q.rvalid <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign cfg_rdata = s_q.rdata;
  assign cfg_rvalid = s_q.rvalid;
  // busy covers the merge cycle after the last answer
  assign preload_busy = busy || s_q.kick || word_valid;
  assign preload_done = s_q.done;
  assign link_layer_timer_control = s_q.lltc;
  assign port_phy_control = s_q.phy;
  assign power_mgmt_capability_control = s_q.pm;
endmodule

// *** hw/epcp_word_fetch.sv ***
`timescale 1ns/1ps
`include "epcp_params.svh"
module epcp_word_fetch (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic start,
  output logic eep_req,
  output logic [7:0] eep_addr,
  input wire logic eep_ack,
  input wire logic [15:0] eep_rdata,
  output logic word_valid,
  output logic [3:0] word_step,
  output logic [15:0] word_data,
  output logic busy
);
  import epcp_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [1:0] {
    EPCP_ST_IDLE = 2'b00,
    EPCP_ST_REQ = 2'b01,
    EPCP_ST_GAP = 2'b11,
    EPCP_ST_DONE = 2'b10
  } epcp_fstate_t;

  typedef struct packed {
    epcp_fstate_t st;
    logic [3:0] step;
    logic [7:0] addr;
    logic [15:0] word;
    logic [3:0] wstep;
    logic wvalid;
  } epcp_fetch_t;

  epcp_fetch_t s_q;
  epcp_fetch_t s_d;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.wvalid = 1'b0;
    unique case (s_q.st)
      EPCP_ST_IDLE, EPCP_ST_DONE: begin
        if (start) begin
          s_d.st = EPCP_ST_REQ;
          s_d.step = 4'h0;
          s_d.addr = epcp_step_decode(4'h0).addr;
        end
      end
      EPCP_ST_REQ: begin
        if (eep_ack) begin
          s_d.word = eep_rdata;
          s_d.wstep = s_q.step;
          s_d.wvalid = 1'b1;
          s_d.st = (s_q.step == `EPCP_LAST_STEP) ? EPCP_ST_DONE : EPCP_ST_GAP;
        end
      end
      EPCP_ST_GAP: begin
        s_d.step = s_q.step + 4'h1;
        s_d.addr = epcp_step_decode(s_q.step + 4'h1).addr;
        s_d.st = EPCP_ST_REQ;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_q <= '{st: EPCP_ST_IDLE, step: 4'h0, addr: 8'h00, word: 16'h0000,
               wstep: 4'h0, wvalid: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign eep_req = (s_q.st == EPCP_ST_REQ);
  assign eep_addr = s_q.addr;
  assign word_valid = s_q.wvalid;
  assign word_step = s_q.wstep;
  assign word_data = s_q.word;
  assign busy = (s_q.st == EPCP_ST_REQ) || (s_q.st == EPCP_ST_GAP);
endmodule
